// >>> hdl/anbc_params.svh
`ifndef ANBC_PARAMS_SVH
`define ANBC_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets of the controller's own port
// ------------------------------------------------------------
`define ANBC_ADDR_CTRL 4'h0
`define ANBC_ADDR_CMD 4'h1
`define ANBC_ADDR_WDATA 4'h2
`define ANBC_ADDR_RDATA 4'h3
`define ANBC_ADDR_STATUS 4'h4
`define ANBC_ADDR_TIMING 4'h5

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ANBC_CTRL_WP_BIT 0
`define ANBC_CTRL_CE_BIT 1
`define ANBC_CTRL_WIDE_BIT 2
`define ANBC_CTRL_LATE_BIT 3
`define ANBC_STAT_BUSY_BIT 0
`define ANBC_STAT_RB_BIT 1
`define ANBC_STAT_WAIT_BIT 2
`define ANBC_STAT_RVALID_BIT 3

// Operation codes written to the command register bits [9:8]
`define ANBC_OP_CMD 2'h0
`define ANBC_OP_ADDR 2'h1
`define ANBC_OP_WDATA 2'h2
`define ANBC_OP_RDATA 2'h3

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define ANBC_CTRL_RESET 4'h0
`define ANBC_CLK_PERIOD_NS 5
`define ANBC_FAST_CYCLE_LIMIT_NS 30
`define ANBC_STROBE_LOW_CYCLES 8'h04
`define ANBC_STROBE_HIGH_CYCLES 8'h04
`define ANBC_PROTECT_WAIT_NS 100
`define ANBC_PROTECT_WAIT_CYCLES ((`ANBC_PROTECT_WAIT_NS + `ANBC_CLK_PERIOD_NS - 1) / `ANBC_CLK_PERIOD_NS)

`endif

// >>> hdl/anbc_pkg.sv
package anbc_pkg;

    typedef enum logic [2:0]
    {
        anbc_idle_type_s = 3'h0,
        anbc_setup_s = 3'h1,
        anbc_low_s = 3'h3,
        anbc_high_s = 3'h2,
        anbc_done_s = 3'h6
    } anbc_state_type;

    typedef logic [1:0] anbc_op_type;

endpackage : anbc_pkg

// >>> hdl/anbc_wait_timer.sv
`timescale 1ns/10ps

// Down counter giving a one-cycle pulse when a programmed wait has run out.
module anbc_wait_timer #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [WIDTH-1:0] load,
    output logic running,
    output logic expired
);

    logic [WIDTH-1:0] count;

    always_ff @(posedge clk)
    begin
        if (!resetn)
            count <= '0;
        else if (start)
            count <= load;
        else if (count != '0)
            count <= count - 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            expired <= 1'b0;
        else
            expired <= !start && (count == {{(WIDTH-1){1'b0}}, 1'b1});
    end

    assign running = (count != '0);

endmodule : anbc_wait_timer

// >>> hdl/anbc_host.sv
`timescale 1ns/10ps
`include "anbc_params.svh"

// Overview of operation
// - Command strobed with CLE high, ALE low.
// - Upper byte zero in every command cycle.
// - Address strobed with ALE high, CLE low.
// - Host supplies address bytes, unused bits low.
// - Write data strobed with both latches low.
// - Sample on rise if cycle >= 30ns.
// - Issue 00h after 78h before array reads (left to software; the host sends bytes as written).
// - Change protect only ready, then wait.
// - Host may free bus while busy.
// - Hold protect low until supply stable.
// - Commands, addresses on low byte only.
module anbc_host #(
    parameter int DATA_WIDTH = 16,
    parameter int TIMING_WIDTH = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic chip_select_n,
    output logic command_latch_strobe,
    output logic address_latch_strobe,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic write_protect_n,
    output logic [DATA_WIDTH-1:0] data_out,
    output logic data_oe,
    input wire logic [DATA_WIDTH-1:0] data_in,
    input wire logic ready_busy_n
);
    import anbc_pkg::*;

    // ------------------------------------------------------------
    // Software-visible state
    // ------------------------------------------------------------
    logic wp_level;
    logic ce_hold;
    logic wide_bus;
    logic sample_late;
    logic [TIMING_WIDTH-1:0] low_cycles;
    logic [TIMING_WIDTH-1:0] high_cycles;
    logic [DATA_WIDTH-1:0] write_word;
    logic [DATA_WIDTH-1:0] read_word;
    logic read_valid;
    logic late_armed;
    logic ready_line;

    anbc_state_type state;
    anbc_op_type op;
    logic [7:0] op_byte;
    logic [TIMING_WIDTH-1:0] phase_count;
    logic fresh_sample;

    logic protect_start;
    logic protect_wait;
    logic protect_done;

    logic cmd_write;
    logic ctrl_write;
    logic launch;

    assign cmd_write = reg_write && (reg_addr == `ANBC_ADDR_CMD);
    assign ctrl_write = reg_write && (reg_addr == `ANBC_ADDR_CTRL);
    // Refuse new cycles while one runs or the protect settle wait is open
    assign launch = cmd_write && (state == anbc_idle_type_s) && !protect_wait;

    function automatic logic [TIMING_WIDTH-1:0] at_least_one(input logic [TIMING_WIDTH-1:0] v);
        at_least_one = (v == '0) ? {{(TIMING_WIDTH-1){1'b0}}, 1'b1} : v;
    endfunction : at_least_one

    // A zero count is taken as one, so a phase never wraps through the top
    function automatic logic phase_last(input logic [TIMING_WIDTH-1:0] n);
        phase_last = (n <= {{(TIMING_WIDTH-1){1'b0}}, 1'b1});
    endfunction : phase_last

    // ------------------------------------------------------------
    // Ready line sampling
    // ------------------------------------------------------------
    // Pin is open-drain and pulled up outside, so low from any target means busy
    always_ff @(posedge clk)
    begin
        if (!resetn)
            ready_line <= 1'b0;
        else
            ready_line <= ready_busy_n;
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Protect is low from reset so nothing can program while power settles
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wp_level <= 1'b0;
            ce_hold <= 1'b0;
            wide_bus <= 1'b0;
            sample_late <= 1'b0;
        end
        else if (ctrl_write)
        begin
            // Protect may change only between bus cycles with the target ready
            if (state == anbc_idle_type_s && ready_line && !protect_wait)
                wp_level <= reg_wdata[`ANBC_CTRL_WP_BIT];
            ce_hold <= reg_wdata[`ANBC_CTRL_CE_BIT];
            wide_bus <= reg_wdata[`ANBC_CTRL_WIDE_BIT];
            sample_late <= reg_wdata[`ANBC_CTRL_LATE_BIT];
        end
    end

    assign protect_start = ctrl_write && (state == anbc_idle_type_s) && ready_line && !protect_wait
        && (reg_wdata[`ANBC_CTRL_WP_BIT] != wp_level);

    anbc_wait_timer #(
        .WIDTH(16)
    ) u_protect_timer (
        .clk(clk),
        .resetn(resetn),
        .start(protect_start),
        .load(16'(`ANBC_PROTECT_WAIT_CYCLES)),
        .running(protect_wait),
        .expired(protect_done)
    );

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            // Default widths keep a read cycle above the fast-cycle limit
            low_cycles <= TIMING_WIDTH'(`ANBC_STROBE_LOW_CYCLES);
            high_cycles <= TIMING_WIDTH'(`ANBC_STROBE_HIGH_CYCLES);
        end
        else if (reg_write && reg_addr == `ANBC_ADDR_TIMING)
        begin
            low_cycles <= at_least_one(reg_wdata[TIMING_WIDTH-1:0]);
            high_cycles <= at_least_one(reg_wdata[16+TIMING_WIDTH-1:16]);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            write_word <= '0;
        else if (reg_write && reg_addr == `ANBC_ADDR_WDATA)
            write_word <= reg_wdata[DATA_WIDTH-1:0];
    end

    // ------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state <= anbc_idle_type_s;
            op <= `ANBC_OP_CMD;
            op_byte <= 8'h00;
            phase_count <= '0;
        end
        else
        begin
            case (state)
                anbc_idle_type_s:
                begin
                    if (launch)
                    begin
                        op <= reg_wdata[9:8];
                        // Bytes go out as written; ordering such as 00h after 78h is up to software
                        op_byte <= reg_wdata[7:0];
                        phase_count <= high_cycles;
                        state <= anbc_setup_s;
                    end
                end
                anbc_setup_s:
                begin
                    // Latch strobes and data settle before the strobe falls
                    if (phase_last(phase_count))
                    begin
                        phase_count <= low_cycles;
                        state <= anbc_low_s;
                    end
                    else
                        phase_count <= phase_count - 1'b1;
                end
                anbc_low_s:
                begin
                    if (phase_last(phase_count))
                    begin
                        phase_count <= high_cycles;
                        state <= anbc_high_s;
                    end
                    else
                        phase_count <= phase_count - 1'b1;
                end
                anbc_high_s:
                begin
                    // Hold after the rising edge so the target latches cleanly
                    if (phase_last(phase_count))
                        state <= anbc_done_s;
                    else
                        phase_count <= phase_count - 1'b1;
                end
                anbc_done_s:
                    state <= anbc_idle_type_s;
                default:
                    state <= anbc_idle_type_s;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic active;
    logic strobe_low;
    assign active = (state != anbc_idle_type_s) && (state != anbc_done_s);
    assign strobe_low = (state == anbc_low_s);

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            chip_select_n <= 1'b1;
            command_latch_strobe <= 1'b0;
            address_latch_strobe <= 1'b0;
            write_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            data_out <= '0;
            data_oe <= 1'b0;
        end
        else
        begin
            // Releasing select between cycles frees the shared bus and lets the target idle
            chip_select_n <= !(active || ce_hold);
            // At most one latch strobe at a time; both low selects the data phase
            command_latch_strobe <= active && (op == `ANBC_OP_CMD);
            address_latch_strobe <= active && (op == `ANBC_OP_ADDR);
            write_strobe_n <= !(strobe_low && op != `ANBC_OP_RDATA);
            read_strobe_n <= !(strobe_low && op == `ANBC_OP_RDATA);
            // Read cycles leave the data lines to the target
            data_oe <= active && (op != `ANBC_OP_RDATA);
            if (op == `ANBC_OP_WDATA)
                data_out <= wide_bus ? write_word : {{(DATA_WIDTH-8){1'b0}}, write_word[7:0]};
            else
                // Upper byte forced low; software supplies zeroes for unused address bits
                data_out <= {{(DATA_WIDTH-8){1'b0}}, op_byte};
        end
    end

    // ------------------------------------------------------------
    // Read capture
    // ------------------------------------------------------------
    // Slow cycles sample at the rising edge; fast cycles need the late sample
    // taken at the following rising edge, which software chains by issuing
    // the next read before fetching the word.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            fresh_sample <= 1'b0;
        else
            fresh_sample <= (state == anbc_low_s) && phase_last(phase_count) && (op == `ANBC_OP_RDATA);
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            read_word <= '0;
            read_valid <= 1'b0;
            late_armed <= 1'b0;
        end
        else if (fresh_sample)
        begin
            read_word <= wide_bus ? data_in : {{(DATA_WIDTH-8){1'b0}}, data_in[7:0]};
            // In late mode the first read of a chain only primes it
            late_armed <= sample_late;
            read_valid <= !sample_late || late_armed;
        end
        else if (reg_read && reg_addr == `ANBC_ADDR_RDATA)
            read_valid <= 1'b0;
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
            reg_rdata <= 32'h00000000;
        else if (reg_read)
        begin
            case (reg_addr)
                `ANBC_ADDR_CTRL:
                    reg_rdata <= {28'h0000000, sample_late, wide_bus, ce_hold, wp_level};
                `ANBC_ADDR_CMD:
                    reg_rdata <= {22'h000000, op, op_byte};
                `ANBC_ADDR_WDATA:
                    reg_rdata <= 32'(write_word);
                `ANBC_ADDR_RDATA:
                    reg_rdata <= 32'(read_word);
                `ANBC_ADDR_STATUS:
                    reg_rdata <= {28'h0000000, read_valid, protect_wait, ready_line, state != anbc_idle_type_s};
                `ANBC_ADDR_TIMING:
                    reg_rdata <= {8'h00, 8'(high_cycles), 8'h00, 8'(low_cycles)};
                default:
                    reg_rdata <= 32'h00000000;
            endcase
        end
        else
            reg_rdata <= 32'h00000000;
    end

    // ------------------------------------------------------------
    // Write protect pin
    // ------------------------------------------------------------
    // Follows the control flop at all times, selected or not; reset leaves it low
    assign write_protect_n = wp_level;

    // Completion pulse of the protect wait is not needed beyond the wait flag
    logic unused_done;
    assign unused_done = protect_done;

endmodule : anbc_host

// >>> sim/anbc_host_checker.sv
`timescale 1ns/10ps
module anbc_host_checker #(
    parameter int DATA_WIDTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic chip_select_n,
    input wire logic command_latch_strobe,
    input wire logic address_latch_strobe,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_protect_n,
    input wire logic [DATA_WIDTH-1:0] data_out,
    input wire logic data_oe,
    input wire logic ready_busy_n
);
    // Slack of one cycle for where the design starts its wait
    localparam int WAIT = 19;
    logic [7:0] wp_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    always_ff @(posedge clk)
    begin
        if (!resetn)
            wp_cnt <= 8'hFF;
        else if ($changed(write_protect_n))
            wp_cnt <= 8'h00;
        else if (wp_cnt != 8'hFF)
            wp_cnt <= wp_cnt + 8'h01;
    end
    property p_cmd_alone;
        command_latch_strobe |-> !address_latch_strobe && !chip_select_n;
    endproperty
    a_cmd_alone: assert property (p_cmd_alone) else $error("latch clash");
    property p_we_qual;
        !write_strobe_n |-> !chip_select_n && read_strobe_n && data_oe;
    endproperty
    a_we_qual: assert property (p_we_qual) else $error("write strobe qual");
    property p_we_stable;
        !write_strobe_n |-> $stable(command_latch_strobe) && $stable(address_latch_strobe) && $stable(data_out);
    endproperty
    a_we_stable: assert property (p_we_stable) else $error("moved under strobe");
    property p_re_qual;
        !read_strobe_n |-> !chip_select_n && !command_latch_strobe && !address_latch_strobe && write_strobe_n && !data_oe;
    endproperty
    a_re_qual: assert property (p_re_qual) else $error("read strobe qual");
    property p_we_width;
        $fell(write_strobe_n) |-> !write_strobe_n[*4] ##1 write_strobe_n;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write width");
    property p_re_width;
        $fell(read_strobe_n) |-> !read_strobe_n[*4] ##1 read_strobe_n[*4];
    endproperty
    a_re_width: assert property (p_re_width) else $error("read cycle");
    property p_upper_zero;
        data_oe && (command_latch_strobe || address_latch_strobe) |-> data_out[DATA_WIDTH-1:8] == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper byte set");
    property p_wp_wait;
        $fell(chip_select_n) |-> wp_cnt >= WAIT;
    endproperty
    a_wp_wait: assert property (p_wp_wait) else $error("protect wait");
    property p_wp_quiet;
        $changed(write_protect_n) |-> $past(ready_busy_n, 2) && !command_latch_strobe && !address_latch_strobe
            && write_strobe_n && read_strobe_n;
    endproperty
    a_wp_quiet: assert property (p_wp_quiet) else $error("protect moved mid-cycle");
endmodule : anbc_host_checker

bind anbc_host anbc_host_checker #(.DATA_WIDTH(DATA_WIDTH)) anbc_host_checker_inst (
    .clk(clk), .resetn(resetn), .chip_select_n(chip_select_n),
    .command_latch_strobe(command_latch_strobe), .address_latch_strobe(address_latch_strobe),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .write_protect_n(write_protect_n), .data_out(data_out), .data_oe(data_oe),
    .ready_busy_n(ready_busy_n));

// >>> sim/anbc_nand_model.sv
`timescale 1ns/10ps
module anbc_nand_model (
    input wire logic cs_n,
    input wire logic cmd_en,
    input wire logic adr_en,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic wp_n,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic pull_low
);
    logic [15:0] cache [0:3];
    logic [15:0] q = 16'h0000;
    logic [8:0] bcnt = 9'h000;
    logic [1:0] col = 2'h0;
    logic smode = 1'b0;
    logic drv = 1'b0;
    logic abort = 1'b0;
    logic prog = 1'b0;
    logic busy;
    logic [7:0] stat;
    logic [7:0] c;
    assign busy = bcnt != 9'h000;
    assign pull_low = busy;
    assign stat = abort ? 8'h60 : {wp_n, ~busy, ~busy, 5'h00};
    // Released bus shows the inverse, never a stale value
    assign dq_out = drv ? q : ~q;
    always #5 if (busy) bcnt = bcnt - 9'h001;
    always @(wp_n) if (busy && prog) {bcnt, abort} = {9'h000, 1'b1};
    always @(posedge wr_n)
    begin
        c = dq_in[7:0];
        if (cs_n || !rd_n)
            ;
        else if (cmd_en && !adr_en && (!busy || c == 8'h70 || c == 8'h78))
        begin
            smode = c == 8'h70 || c == 8'h78;
            if (!smode)
                {col, abort} = 3'h0;
            prog = c == 8'h10 && wp_n;
            if (prog || c == 8'h30)
                bcnt = prog ? 9'h12C : 9'h014;
        end
        else if (adr_en && !cmd_en && (!busy || smode))
            col = 2'h0;
        else if (!adr_en && !cmd_en && !busy)
        begin
            cache[col] = dq_in;
            col = col + 2'h1;
        end
    end
    always @(negedge rd_n)
        if (!cs_n && !adr_en && !cmd_en && wr_n && (smode || !busy))
        begin
            q = smode ? {8'h00, stat} : cache[col];
            col = smode ? col : col + 2'h1;
            drv = 1'b1;
        end
    always @(posedge rd_n or posedge cs_n) drv = 1'b0;
endmodule : anbc_nand_model

// >>> sim/tb_anbc_host.sv
`timescale 1ns/10ps
`include "anbc_params.svh"
module tb_anbc_host;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic rd_d = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [31:0] v;
    logic cs_n, cle, ale, we_n, re_n, wp_n, oe, busy;
    logic [15:0] dout, dev_q, dq, w0, w1;
    logic [63:0] exp_q [$];
    logic [63:0] e;
    int mismatches = 0;
    int samples_checked = 0;
    int cyc = 0;
    int seed = 32'hC9EB;
    assign dq = oe ? dout : dev_q;
    always #2.5 clk = ~clk;
    anbc_host anbc_host_inst (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .chip_select_n(cs_n),
        .command_latch_strobe(cle), .address_latch_strobe(ale), .write_strobe_n(we_n),
        .read_strobe_n(re_n), .write_protect_n(wp_n), .data_out(dout), .data_oe(oe),
        .data_in(dq), .ready_busy_n(busy ? 1'b0 : 1'b1));
    anbc_nand_model anbc_nand_model_inst (.cs_n(cs_n), .cmd_en(cle), .adr_en(ale), .wr_n(we_n),
        .rd_n(re_n), .wp_n(wp_n), .dq_in(dq), .dq_out(dev_q), .pull_low(busy));
    task automatic end_sim;
        $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    always @(posedge clk)
    begin
        rd_d <= reg_read;
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            end_sim;
        end
        if (rd_d)
        begin
            e = exp_q.pop_front();
            if (e[63:32] != 32'h0)
            begin
                samples_checked++;
                if ((reg_rdata & e[63:32]) !== e[31:0])
                begin
                    mismatches++;
                    $display("ERROR t=%0t got=%h exp=%h", $time, reg_rdata & e[63:32], e[31:0]);
                end
            end
        end
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] x);
        exp_q.push_back({m, x});
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    // Polls are bounded so a stuck flag ends as a mismatch
    task automatic wait_st(input logic [31:0] m, input logic [31:0] x);
        int i;
        for (i = 0; i < 400; i++)
        begin
            rd(`ANBC_ADDR_STATUS, 32'h0, 32'h0);
            if ((v & m) === x)
                break;
        end
        if (i == 400)
            mismatches++;
    endtask : wait_st
    task automatic op(input logic [1:0] o, input logic [7:0] b);
        wr(`ANBC_ADDR_CMD, {22'h0, o, b});
        wait_st(32'h5, 32'h0);
    endtask : op
    task automatic prep(input logic [7:0] c);
        int i;
        op(`ANBC_OP_CMD, c);
        for (i = 0; i < 5; i++)
            op(`ANBC_OP_ADDR, 8'($random(seed)) & 8'h07);
    endtask : prep
    task automatic put(input logic [15:0] w);
        wr(`ANBC_ADDR_WDATA, {16'h0, w});
        op(`ANBC_OP_WDATA, 8'h00);
    endtask : put
    task automatic get(input logic [31:0] m, input logic [31:0] x);
        op(`ANBC_OP_RDATA, 8'h00);
        rd(`ANBC_ADDR_RDATA, m, x);
    endtask : get
    initial
    begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(`ANBC_ADDR_CTRL, 32'hF, 32'h0);
        rd(`ANBC_ADDR_TIMING, 32'hFF00FF, 32'h40004);
        rd(`ANBC_ADDR_STATUS, 32'hF, 32'h2);
        rd(4'hF, 32'hFFFFFFFF, 32'h0);
        $display("Test reset_values done");
        w0 = 16'($random(seed));
        w1 = 16'($random(seed));
        wr(`ANBC_ADDR_CTRL, 32'h5);
        wait_st(32'h4, 32'h0);
        prep(8'h80);
        put(w0);
        put(w1);
        op(`ANBC_OP_CMD, 8'h10);
        rd(`ANBC_ADDR_STATUS, 32'h2, 32'h0);
        wr(`ANBC_ADDR_CTRL, 32'h4);
        rd(`ANBC_ADDR_CTRL, 32'h1, 32'h1);
        op(`ANBC_OP_CMD, 8'h70);
        get(32'hFF, 32'h80);
        wait_st(32'h2, 32'h2);
        op(`ANBC_OP_CMD, 8'h70);
        get(32'hFF, 32'hE0);
        $display("Test program_busy done");
        prep(8'h00);
        op(`ANBC_OP_CMD, 8'h30);
        wait_st(32'h2, 32'h2);
        op(`ANBC_OP_CMD, 8'h00);
        get(32'hFFFF, {16'h0, w0});
        get(32'hFFFF, {16'h0, w1});
        $display("Test array_read done");
        wr(`ANBC_ADDR_CTRL, 32'h4);
        wait_st(32'h4, 32'h0);
        rd(`ANBC_ADDR_CTRL, 32'hF, 32'h4);
        prep(8'h80);
        put(16'($random(seed)));
        op(`ANBC_OP_CMD, 8'h10);
        rd(`ANBC_ADDR_STATUS, 32'h2, 32'h2);
        op(`ANBC_OP_CMD, 8'h70);
        get(32'hFF, 32'h60);
        $display("Test protect done");
        wr(`ANBC_ADDR_CTRL, 32'hC);
        rd(`ANBC_ADDR_CTRL, 32'hF, 32'hC);
        op(`ANBC_OP_CMD, 8'h00);
        op(`ANBC_OP_RDATA, 8'h00);
        rd(`ANBC_ADDR_STATUS, 32'h8, 32'h0);
        op(`ANBC_OP_RDATA, 8'h00);
        rd(`ANBC_ADDR_STATUS, 32'h8, 32'h8);
        rd(`ANBC_ADDR_RDATA, 32'hFFFF, {16'h0, w1});
        rd(`ANBC_ADDR_STATUS, 32'h8, 32'h0);
        $display("Test late_sample done");
        repeat (3) @(posedge clk);
        end_sim;
    end
endmodule : tb_anbc_host
